// ==== rtl/avs_pkg.sv ====
// Shared constants and types of the avionics transmit, schedule and snapshot block.
package avs_pkg;
    // ****************************************************************
    // Sizes and timing
    // ****************************************************************
    localparam int TX_CH = 16;
    localparam int SCHED_ENTRIES = 1024;
    localparam int INTQ_DEPTH = 2048;
    localparam int TXF_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 4;
    localparam int EPOCH_NS = 1000000;
    localparam int EPOCH_CYCLES = EPOCH_NS / CLK_PERIOD_NS;
    // ****************************************************************
    // Host word address map
    // ****************************************************************
    localparam logic [17:0] A_SCHED_BASE = 18'h10000;
    localparam logic [17:0] A_INTQ_BASE = 18'h12000;
    localparam logic [17:0] A_INTQ_REG = 18'h13000;
    localparam logic [17:0] A_GLOBAL = 18'h13001;
    localparam logic [17:0] A_BUF_BASE = 18'h13100;
    localparam logic [17:0] A_CFG_BASE = 18'h13200;
    localparam logic [17:0] A_STAT_BASE = 18'h13300;
    // ****************************************************************
    // Field positions, codes and reset values
    // ****************************************************************
    localparam int G_SCHED_EN = 0;
    localparam int G_SNAP_MODE = 1;
    localparam int C_PAR_EN = 0;
    localparam int C_PAR_ODD = 1;
    localparam int C_PROTO = 2;
    localparam logic [1:0] PROTO_561 = 2'h1;
    localparam logic [1:0] PROTO_717 = 2'h2;
    localparam int S_NOT_FULL = 0;
    localparam int S_NOT_EMPTY = 1;
    localparam logic [1:0] BW_ADVANCE = 2'h2;
    localparam logic [1:0] BW_PAYLOAD = 2'h3;
    localparam logic [2:0] EL_RATE = 3'h0;
    localparam logic [2:0] EL_CHAN = 3'h1;
    localparam logic [2:0] EL_COUNT = 3'h2;
    localparam logic [2:0] EL_CD = 3'h3;
    localparam logic [2:0] EL_DATA = 3'h7;
    localparam logic [7:0] INTQ_RX_BASE = 8'h40;
    localparam logic [7:0] INTQ_HOST_CODE = 8'hFF;
    localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
    localparam logic [1:0] GLOBAL_RESET = 2'h0;
    localparam logic [3:0] CFG_RESET = 4'h0;
    // Scheduler walk states.
    typedef enum logic [1:0] {S_IDLE, S_WALK, S_PUSH} avs_sched_t;
endpackage

// ==== rtl/avs_fifo.sv ====
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module avs_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } avs_fifo_st_t;
    avs_fifo_st_t st_r;
    avs_fifo_st_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    // Pointers carry one wrap bit so full and empty are exact.
    assign empty = st_r.wp == st_r.rp;
    assign full = (st_r.wp[AW] != st_r.rp[AW]) && (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st_r.rp[AW-1:0]];

    // Next pointer values.
    always_comb begin
        st_nxt = st_r;
        if (in_valid && !full) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
    end

    // State and storage registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
        if (in_valid && !full) begin
            mem[st_r.wp[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== rtl/avs_intq.sv ====
// Interrupt source queue with a head pointer to the newest entry.
`timescale 1ns/1ps
module avs_intq import avs_pkg::*; #(
    parameter int DEPTH = INTQ_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic push_rx,
    input wire logic [7:0] rx_code,
    input wire logic push_host,
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [$clog2(DEPTH)-1:0] head,
    output logic [31:0] rd_data
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [PW-1:0] head;
    } avs_intq_st_t;
    avs_intq_st_t st_r;
    avs_intq_st_t st_nxt;
    logic [31:0] q_mem [DEPTH];
    logic [PW-1:0] a_slot;
    logic [PW-1:0] b_slot;

    // Both sources may push in one cycle; the receive entry goes first.
    always_comb begin
        st_nxt = st_r;
        a_slot = st_r.head + 1'b1;
        b_slot = push_rx ? st_r.head + 2'h2 : a_slot;
        st_nxt.head = st_r.head + PW'(push_rx) + PW'(push_host);
    end

    // Head starts at the last slot so the first entry lands in slot zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.head <= '1;
        end else begin
            st_r <= st_nxt;
        end
        if (push_rx) begin
            q_mem[a_slot] <= {24'h0, rx_code};
        end
        if (push_host) begin
            q_mem[b_slot] <= {24'h0, INTQ_HOST_CODE};
        end
    end

    assign head = st_r.head;
    assign rd_data = q_mem[rd_idx];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_head_step: assert property (push_host && !push_rx |=> head == $past(head) + 1'b1)
        else $error("Head pointer did not move to the host entry.");
    a_host_code: assert property (push_host |=> q_mem[$past(b_slot)] == 32'h0000_00FF)
        else $error("Host entry code is not 255.");
    a_rx_code: assert property (push_rx |=> q_mem[$past(a_slot)][7:6] == 2'h1)
        else $error("Receive entry code is outside 64 to 127.");
endmodule

// ==== rtl/avs_top.sv ====
// Transmit FIFOs, scheduler, interrupt queue and snapshot store of the avionics interface.
// Contract
// - Frame marker set for sync, cleared for data.
// - Subframe code 1 to 3, four as 0.
// - Word three top byte write advances FIFO.
// - Parity enabled replaces bit 31 with parity.
// - Parity off or 561 keeps bit 31.
// - Frame transmit takes only low 12 bits.
// - Interrupt queue holds 2048 entries of 32 bits.
// - Head pointer names newest entry, host readable.
// - Codes: receive channel plus 64, host 255.
// - Scheduler table 1024 entries of eight elements.
// - Enable bit leaves table contents untouched.
// - Walk whole table each millisecond, ascending.
// - Enable changes apply only at epoch boundary.
// - Rate zero unused, otherwise period in milliseconds.
// - Channel, count, countdown writable only when disabled.
// - Count zero silent, N words, ones unlimited.
// - Start adds rate, countdown, send, reload rate-1.
// - Snapshot 256 labels by four words, 64 channels.
// - Mode 0 by label, mode 1 adds SDI.
// - Offset is channel, label, then slot or SDI.
// - Receive with interrupt bit enqueues channel source.
`timescale 1ns/1ps
module avs_top import avs_pkg::*; #(
    parameter int EPOCH_CLKS = EPOCH_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic HOST_WR,
    input wire logic HOST_RD,
    input wire logic [17:0] HOST_ADDR,
    input wire logic [3:0] HOST_BE,
    input wire logic [31:0] HOST_WDATA,
    output logic [31:0] HOST_RDATA,
    output logic HOST_RVALID,
    output logic [TX_CH-1:0] TX_VALID,
    output logic [TX_CH*32-1:0] TX_DATA,
    input wire logic [TX_CH-1:0] TX_READY,
    input wire logic RX_VALID,
    input wire logic [5:0] RX_CHANNEL,
    input wire logic [31:0] RX_WORD,
    input wire logic [63:0] RX_TTAG,
    input wire logic RX_INT_EN,
    input wire logic RX_SNAP_FILT,
    input wire logic FRM_VALID,
    input wire logic FRM_SYNC,
    input wire logic [2:0] FRM_SUBFRAME,
    input wire logic [11:0] FRM_DATA,
    output logic [31:0] FRM_WORD,
    output logic FRM_WORD_VALID
);
    // ****************************************************************
    // State and storage
    // ****************************************************************
    typedef struct packed {
        avs_sched_t st;
        logic [9:0] idx;
        logic [31:0] div;
        logic sched_on;
        logic starting;
        logic [1:0] glob;
        logic [TX_CH*4-1:0] cfg;
        logic [TX_CH*32-1:0] stage;
        logic [3:0] pch;
        logic [31:0] pdata;
        logic [31:0] rdata;
        logic rvalid;
        logic [31:0] fword;
        logic fvalid;
    } avs_main_t;
    avs_main_t st_r;
    avs_main_t st_nxt;

    // Scheduler table elements; elements 4 to 6 are not stored.
    logic [31:0] rate_mem [SCHED_ENTRIES];
    logic [31:0] chan_mem [SCHED_ENTRIES];
    logic [31:0] cnt_mem [SCHED_ENTRIES];
    logic [31:0] cd_mem [SCHED_ENTRIES];
    logic [31:0] data_mem [SCHED_ENTRIES];
    // Snapshot lines: channel and label select a line of four words.
    logic [127:0] snap_mem [64*256];

    logic tick;
    logic s_wr;
    logic send;
    logic [31:0] cd_w;
    logic [31:0] cnt_w;
    logic sched_push;
    logic [TX_CH-1:0] host_push;
    logic [TX_CH-1:0] fin_v;
    logic [TX_CH-1:0] fin_rdy;
    logic [TX_CH-1:0] fout_v;
    logic [TX_CH*32-1:0] fin_d;
    logic sch_hw;
    logic [9:0] he;
    logic [2:0] hel;
    logic snap_we;
    logic [13:0] sidx;
    logic [10:0] iq_head;
    logic [31:0] iq_data;
    logic [31:0] e_rate;
    logic [31:0] e_cnt;
    logic [31:0] e_cd;

    // Region match on the upper address bits above a power-of-two span.
    function automatic logic hit(input logic [17:0] a, input logic [17:0] base, input int lg);
        return (a >> lg) == (base >> lg);
    endfunction

    // Outgoing word shaping by channel protocol and parity setting.
    function automatic logic [31:0] tx_fmt(input logic [31:0] w, input logic [3:0] c);
        logic [31:0] o;
        o = w;
        if (c[C_PROTO+1:C_PROTO] == PROTO_717) begin
            o = {20'h0, w[11:0]};
        end else if (c[C_PAR_EN] && c[C_PROTO+1:C_PROTO] != PROTO_561) begin
            o[31] = c[C_PAR_ODD] ? ~^w[30:0] : ^w[30:0];
        end
        return o;
    endfunction

    // ****************************************************************
    // Address decode and shared strobes
    // ****************************************************************
    // Each channel pushes when word three is written with its top byte lane.
    always_comb begin
        for (int c = 0; c < TX_CH; c++) begin
            host_push[c] = HOST_WR && hit(HOST_ADDR, A_BUF_BASE, 6) && HOST_BE[3]
                && HOST_ADDR[1:0] == BW_ADVANCE && HOST_ADDR[5:2] == 4'(c);
        end
    end

    assign sch_hw = HOST_WR && hit(HOST_ADDR, A_SCHED_BASE, 13);
    assign he = HOST_ADDR[12:3];
    assign hel = HOST_ADDR[2:0];
    assign e_rate = rate_mem[st_r.idx];
    assign e_cnt = cnt_mem[st_r.idx];
    assign e_cd = cd_mem[st_r.idx];
    assign tick = st_r.div == 32'(EPOCH_CLKS - 1);
    assign snap_we = RX_VALID && !RX_SNAP_FILT;
    assign sidx = {RX_CHANNEL, RX_WORD[7:0]};

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Host registers, read mux, frame word format and the scheduler walk.
    always_comb begin
        st_nxt = st_r;
        s_wr = 1'b0;
        send = 1'b0;
        sched_push = 1'b0;
        cd_w = e_cd;
        cnt_w = e_cnt;
        st_nxt.div = tick ? 32'h0 : st_r.div + 32'h1;
        st_nxt.rvalid = HOST_RD;
        st_nxt.fvalid = FRM_VALID;
        if (FRM_VALID) begin
            st_nxt.fword = {16'h0, FRM_SYNC, 1'b0, FRM_SUBFRAME[1:0], FRM_DATA};
        end
        if (HOST_WR && HOST_ADDR == A_GLOBAL) begin
            st_nxt.glob = HOST_WDATA[1:0];
        end
        if (HOST_WR && hit(HOST_ADDR, A_CFG_BASE, 4)) begin
            st_nxt.cfg[HOST_ADDR[3:0]*4 +: 4] = HOST_WDATA[3:0];
        end
        if (HOST_WR && hit(HOST_ADDR, A_BUF_BASE, 6) && HOST_ADDR[1:0] == BW_PAYLOAD) begin
            for (int b = 0; b < 4; b++) begin
                if (HOST_BE[b]) begin
                    st_nxt.stage[HOST_ADDR[5:2]*32 + b*8 +: 8] = HOST_WDATA[b*8 +: 8];
                end
            end
        end
        // Read answer, one cycle after the strobe.
        st_nxt.rdata = 32'h0;
        if (HOST_ADDR[17:16] == 2'h0) begin
            st_nxt.rdata = snap_mem[HOST_ADDR[15:2]][{HOST_ADDR[1:0], 5'h0} +: 32];
        end else if (hit(HOST_ADDR, A_SCHED_BASE, 13)) begin
            case (hel)
                EL_RATE: st_nxt.rdata = rate_mem[he];
                EL_CHAN: st_nxt.rdata = chan_mem[he];
                EL_COUNT: st_nxt.rdata = cnt_mem[he];
                EL_CD: st_nxt.rdata = cd_mem[he];
                EL_DATA: st_nxt.rdata = data_mem[he];
                default: st_nxt.rdata = 32'h0;
            endcase
        end else if (hit(HOST_ADDR, A_INTQ_BASE, 11)) begin
            st_nxt.rdata = iq_data;
        end else if (HOST_ADDR == A_INTQ_REG) begin
            st_nxt.rdata = {21'h0, iq_head};
        end else if (HOST_ADDR == A_GLOBAL) begin
            st_nxt.rdata = {30'h0, st_r.glob};
        end else if (hit(HOST_ADDR, A_CFG_BASE, 4)) begin
            st_nxt.rdata = {28'h0, st_r.cfg[HOST_ADDR[3:0]*4 +: 4]};
        end else if (hit(HOST_ADDR, A_STAT_BASE, 4)) begin
            st_nxt.rdata = {30'h0, fout_v[HOST_ADDR[3:0]], fin_rdy[HOST_ADDR[3:0]]};
        end
        // Scheduler walk.
        case (st_r.st)
            S_IDLE: begin
                if (tick) begin
                    st_nxt.sched_on = st_r.glob[G_SCHED_EN];
                    st_nxt.starting = st_r.glob[G_SCHED_EN] && !st_r.sched_on;
                    if (st_r.glob[G_SCHED_EN]) begin
                        st_nxt.st = S_WALK;
                        st_nxt.idx = 10'h0;
                    end
                end
            end
            S_WALK: begin
                if (e_rate != 32'h0) begin
                    s_wr = 1'b1;
                    if (st_r.starting) begin
                        cd_w = e_cd + e_rate;
                    end else if (e_cd != 32'h0) begin
                        cd_w = e_cd - 32'h1;
                    end else begin
                        cd_w = e_rate - 32'h1;
                        if (e_cnt != 32'h0) begin
                            send = 1'b1;
                            if (e_cnt != ALL_ONES) begin
                                cnt_w = e_cnt - 32'h1;
                            end
                        end
                    end
                end
                if (send && chan_mem[st_r.idx] < 32'(TX_CH)) begin
                    st_nxt.st = S_PUSH;
                    st_nxt.pch = chan_mem[st_r.idx][3:0];
                    st_nxt.pdata = data_mem[st_r.idx];
                end else if (st_r.idx == 10'(SCHED_ENTRIES - 1)) begin
                    st_nxt.st = S_IDLE;
                end else begin
                    st_nxt.idx = st_r.idx + 10'h1;
                end
            end
            S_PUSH: begin
                sched_push = 1'b1;
                if (fin_rdy[st_r.pch] && !host_push[st_r.pch]) begin
                    if (st_r.idx == 10'(SCHED_ENTRIES - 1)) begin
                        st_nxt.st = S_IDLE;
                    end else begin
                        st_nxt.st = S_WALK;
                        st_nxt.idx = st_r.idx + 10'h1;
                    end
                end
            end
            default: st_nxt.st = S_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers and memories
    // ****************************************************************
    // Control state resets; table and snapshot contents are left to software.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_r <= '0;
            st_r.st <= S_IDLE;
            st_r.glob <= GLOBAL_RESET;
            st_r.cfg <= {TX_CH{CFG_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Table writes: host guard on disabled entries, walk updates on active ones.
    always_ff @(posedge CLK) begin
        if (s_wr) begin
            cd_mem[st_r.idx] <= cd_w;
            cnt_mem[st_r.idx] <= cnt_w;
        end
        if (sch_hw) begin
            case (hel)
                EL_RATE: rate_mem[he] <= HOST_WDATA;
                EL_DATA: data_mem[he] <= HOST_WDATA;
                EL_CHAN: if (rate_mem[he] == 32'h0) chan_mem[he] <= HOST_WDATA;
                EL_COUNT: if (rate_mem[he] == 32'h0) cnt_mem[he] <= HOST_WDATA;
                EL_CD: if (rate_mem[he] == 32'h0) cd_mem[he] <= HOST_WDATA;
                default: ;
            endcase
        end
        if (snap_we) begin
            if (st_r.glob[G_SNAP_MODE]) begin
                snap_mem[sidx][{RX_WORD[9:8], 5'h0} +: 32] <= RX_WORD;
            end else begin
                snap_mem[sidx] <= {RX_WORD, 32'h0, RX_TTAG};
            end
        end
    end

    // ****************************************************************
    // Transmit FIFOs and interrupt queue
    // ****************************************************************
    for (genvar g = 0; g < TX_CH; g++) begin : g_tx
        assign fin_v[g] = host_push[g] || (sched_push && st_r.pch == 4'(g));
        assign fin_d[g*32 +: 32] = host_push[g]
            ? tx_fmt(st_r.stage[g*32 +: 32], st_r.cfg[g*4 +: 4])
            : tx_fmt(st_r.pdata, st_r.cfg[g*4 +: 4]);
        assign TX_VALID[g] = fout_v[g];
        avs_fifo #(.WIDTH(32), .DEPTH(TXF_DEPTH)) u_fifo (
            .clk(CLK),
            .rst(RESET),
            .in_valid(fin_v[g]),
            .in_ready(fin_rdy[g]),
            .in_data(fin_d[g*32 +: 32]),
            .out_valid(fout_v[g]),
            .out_ready(TX_READY[g]),
            .out_data(TX_DATA[g*32 +: 32])
        );
        a_parity_odd: assert property (@(posedge CLK) disable iff (RESET)
            fin_v[g] && st_r.cfg[g*4+C_PAR_EN] && st_r.cfg[g*4+C_PAR_ODD]
            && st_r.cfg[g*4+C_PROTO+1 -: 2] == 2'h0 |-> ^fin_d[g*32 +: 32])
            else $error("Odd parity word has even weight.");
        a_frame_low12: assert property (@(posedge CLK) disable iff (RESET)
            fin_v[g] && st_r.cfg[g*4+C_PROTO+1 -: 2] == PROTO_717
            |-> fin_d[g*32+12 +: 20] == 20'h0)
            else $error("Frame transmit word has upper bits set.");
        a_bit31_kept: assert property (@(posedge CLK) disable iff (RESET)
            host_push[g] && !st_r.cfg[g*4+C_PAR_EN] && st_r.cfg[g*4+C_PROTO+1 -: 2] != PROTO_717
            |-> fin_d[g*32+31] == st_r.stage[g*32+31])
            else $error("Bit 31 changed with parity off.");
    end

    avs_intq #(.DEPTH(INTQ_DEPTH)) u_intq (
        .clk(CLK),
        .rst(RESET),
        .push_rx(RX_VALID && RX_INT_EN),
        .rx_code(INTQ_RX_BASE + {2'h0, RX_CHANNEL}),
        .push_host(HOST_WR && HOST_ADDR == A_INTQ_REG),
        .rd_idx(HOST_ADDR[10:0]),
        .head(iq_head),
        .rd_data(iq_data)
    );

    assign HOST_RDATA = st_r.rdata;
    assign HOST_RVALID = st_r.rvalid;
    assign FRM_WORD = st_r.fword;
    assign FRM_WORD_VALID = st_r.fvalid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    sequence walk_step;
        st_r.st == S_WALK && st_nxt.st == S_WALK;
    endsequence
    a_frame_sync: assert property (FRM_VALID |=> FRM_WORD[15] == $past(FRM_SYNC))
        else $error("Frame marker does not follow sync detection.");
    a_subframe_four: assert property (FRM_VALID && FRM_SUBFRAME == 3'h4
        |=> FRM_WORD_VALID && FRM_WORD[13:12] == 2'h0)
        else $error("Subframe four not coded as zero.");
    a_push_word3: assert property (|host_push |-> HOST_BE[3] && HOST_ADDR[1:0] == BW_ADVANCE)
        else $error("FIFO advanced without word three top byte.");
    a_walk_order: assert property (walk_step |=> st_r.idx == $past(st_r.idx) + 10'h1)
        else $error("Scheduler skipped or repeated an entry.");
    a_epoch_only: assert property ($changed(st_r.sched_on) |-> $past(tick))
        else $error("Scheduler enable changed off an epoch.");
    a_rate_unused: assert property (st_r.st == S_WALK && e_rate == 32'h0
        |=> st_r.st != S_PUSH)
        else $error("Unused entry produced a word.");
    a_count_zero: assert property (st_r.st == S_WALK && e_cnt == 32'h0
        |=> st_r.st != S_PUSH)
        else $error("Zero count entry produced a word.");
    a_snap_label: assert property (snap_we && !st_r.glob[G_SNAP_MODE]
        |=> snap_mem[$past(sidx)][127:96] == $past(RX_WORD))
        else $error("Label snapshot data slot not written.");
    a_rx_enqueue: assert property (RX_VALID && RX_INT_EN |=> iq_head != $past(iq_head))
        else $error("Interrupt-enabled receive did not enqueue.");
endmodule

// ==== tb/avs_tx_sink.sv ====
// Transmit engine model that takes words from every channel unless stalled.
`timescale 1ns/1ps
module avs_tx_sink (
    input wire logic clk,
    input wire logic stall,
    output logic [15:0] ready
);
    // Ready moves off the sampling edge so a pop never races the FIFO.
    always @(negedge clk) begin
        ready <= stall ? 16'h0000 : 16'hFFFF;
    end
endmodule

// ==== tb/test_avs_top.sv ====
// Self-checking testbench of the avionics transmit, queue and snapshot block.
`timescale 1ns/1ps
module test_avs_top import avs_pkg::*;;
    logic clk = 0, rst = 1, wr = 0, rd = 0, rxv = 0, rxi = 0, frv = 0, frs = 0, stall = 1;
    logic [17:0] addr = 0;
    logic [3:0] be = 4'hF;
    logic [31:0] wd = 0, rxw = 0, rdat, fw, word6;
    logic [63:0] tt = 64'hAAAABBBBCCCCDDDD;
    logic [5:0] rxc = 0;
    logic [2:0] sf = 0;
    logic [11:0] fd = 0;
    logic rv, fv;
    logic [15:0] txv, txr;
    logic [511:0] txd;
    int n_errors = 0, num_checks = 0, pops = 0, pops6 = 0;
    avs_top #(.EPOCH_CLKS(2000)) dut (.CLK(clk), .RESET(rst), .HOST_WR(wr), .HOST_RD(rd),
        .HOST_ADDR(addr), .HOST_BE(be), .HOST_WDATA(wd), .HOST_RDATA(rdat), .HOST_RVALID(rv),
        .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr), .RX_VALID(rxv), .RX_CHANNEL(rxc),
        .RX_WORD(rxw), .RX_TTAG(tt), .RX_INT_EN(rxi), .RX_SNAP_FILT(1'b0), .FRM_VALID(frv),
        .FRM_SYNC(frs), .FRM_SUBFRAME(sf), .FRM_DATA(fd), .FRM_WORD(fw), .FRM_WORD_VALID(fv));
    avs_tx_sink sink (.clk(clk), .stall(stall), .ready(txr));
    always #2 clk = ~clk;
    // Pops of channel five show how many words the full FIFO really kept.
    always @(posedge clk) if (txv[5] && txr[5]) pops <= pops + 1;
    // Pops of channel six count and keep what the scheduler handed over.
    always @(posedge clk) begin
        if (txv[6] && txr[6]) begin
            pops6 <= pops6 + 1;
            word6 <= txd[6*32 +: 32];
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task hw(input logic [17:0] a, input logic [31:0] d, input logic [3:0] b);
        @(negedge clk); wr = 1; addr = a; wd = d; be = b;
        @(negedge clk); wr = 0;
    endtask
    task hr(input logic [17:0] a, input logic [31:0] e, input string n);
        @(negedge clk); rd = 1; addr = a;
        @(negedge clk); rd = 0;
        chk(n, e, (rv === 1'b1) ? rdat : 32'hXXXXXXXX);
    endtask
    task push(input int c, input logic [31:0] d);
        hw(A_BUF_BASE + 18'(c * 4 + 3), d, 4'hF);
        hw(A_BUF_BASE + 18'(c * 4 + 2), 32'h0, 4'h8);
    endtask
    task rxmsg(input logic [31:0] w, input logic ie);
        @(negedge clk); rxv = 1; rxc = 6'h02; rxw = w; rxi = ie;
        @(negedge clk); rxv = 0;
    endtask
    // Each subframe with alternating sync marker, four reported as zero.
    task t_frame;
        for (int i = 1; i < 5; i++) begin
            @(negedge clk); frv = 1; frs = i[0]; sf = 3'(i); fd = 12'h5A0 + 12'(i);
            @(negedge clk); frv = 0;
            chk("frame", {16'h0, i[0], 1'b0, 2'(i % 4), 12'h5A0 + 12'(i)}, fv ? fw : 'x);
        end
    endtask
    // Parity odd, even, 561, off, then 717 payload masking, engine stalled.
    task automatic t_tx;
        logic [3:0] cf[5] = '{4'h3, 4'h1, 4'h5, 4'h0, 4'h8};
        logic [31:0] di[5] = '{32'h3, 32'h80000003, 32'h80000003, 32'h80000001, 32'hFFFFFABC};
        logic [31:0] ex[5] = '{32'h80000003, 32'h3, 32'h80000003, 32'h80000001, 32'hABC};
        for (int i = 0; i < 5; i++) begin
            hw(A_CFG_BASE + 18'(i), 32'(cf[i]), 4'hF);
            push(i, di[i]);
            @(negedge clk);
            chk("tx head", ex[i], txv[i] ? txd[i*32+:32] : 'x);
        end
    endtask
    // Nine pushes into eight places, then drain through the engine.
    task t_fill;
        for (int i = 0; i < 9; i++) push(5, 32'(i));
        hr(A_STAT_BASE + 18'h5, 32'h2, "status full");
        stall = 0;
        repeat (20) @(negedge clk);
        chk("pops", 32'h8, 32'(pops));
        hr(A_STAT_BASE + 18'h5, 32'h1, "status empty");
    endtask
    // Snapshot in both modes, queue codes and head pointer.
    task t_rx;
        rxmsg(32'h12345629, 1);
        hr(18'h008A7, 32'h12345629, "snap data");
        hr(18'h008A4, 32'hCCCCDDDD, "snap ttag");
        hr(A_INTQ_REG, 32'h0, "head");
        hr(A_INTQ_BASE, 32'h42, "rx code");
        hw(A_INTQ_REG, 32'h0, 4'hF);
        hr(A_INTQ_REG, 32'h1, "head");
        hr(A_INTQ_BASE + 18'h1, 32'hFF, "host code");
        hw(A_GLOBAL, 32'h2, 4'hF);
        rxmsg(32'h00000129, 0);
        hr(18'h008A5, 32'h129, "snap sdi");
        hr(A_INTQ_REG, 32'h1, "head");
        hr(18'h3FFFF, 32'h0, "unmapped");
    endtask
    // One word every two 8 us epochs, count of one, channel six.
    task t_sched;
        for (int e = 0; e < 1024; e++) hw(A_SCHED_BASE + 18'(e * 8), 32'h0, 4'hF);
        hw(A_SCHED_BASE + 18'h1, 32'h6, 4'hF);
        hw(A_SCHED_BASE + 18'h2, 32'h1, 4'hF);
        hw(A_SCHED_BASE + 18'h3, 32'h0, 4'hF);
        hw(A_SCHED_BASE + 18'h7, 32'h00C0FFEE, 4'hF);
        hw(A_SCHED_BASE + 18'h0, 32'h2, 4'hF);
        hw(A_SCHED_BASE + 18'h1, 32'h9, 4'hF);
        hw(A_GLOBAL, 32'h3, 4'hF);
        repeat (12000) @(negedge clk);
        hr(A_SCHED_BASE + 18'h2, 32'h0, "count");
        hr(A_SCHED_BASE + 18'h1, 32'h6, "chan");
        chk("sched pops", 32'h1, 32'(pops6));
        chk("sched word", 32'h00C0FFEE, word6);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        t_frame;
        t_tx;
        t_fill;
        t_rx;
        t_sched;
        end_of_test;
    end
endmodule
